/* File: hw/tpou_pkg.sv */
// Package of the timing pattern output unit: register indices, reset values,
// field positions and the pin carrier type.
// Assumes a Wishbone slave with byte address equal to four times the index.
package tpou_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] TPOU_IDX_OUT_MODE = 16'hFFA0;
  localparam logic [15:0] TPOU_IDX_TRIG_SEL = 16'hFFA1;
  localparam logic [15:0] TPOU_IDX_HI_EN = 16'hFFA2;
  localparam logic [15:0] TPOU_IDX_LO_EN = 16'hFFA3;
  localparam logic [15:0] TPOU_IDX_HI_NEXT = 16'hFFA4;
  localparam logic [15:0] TPOU_IDX_LO_NEXT = 16'hFFA5;
  localparam logic [15:0] TPOU_IDX_HI_NEXT_ALT = 16'hFFA6;
  localparam logic [15:0] TPOU_IDX_LO_NEXT_ALT = 16'hFFA7;
  localparam logic [15:0] TPOU_IDX_LO_DIR = 16'hFFD1;
  localparam logic [15:0] TPOU_IDX_LO_DATA = 16'hFFD3;
  localparam logic [15:0] TPOU_IDX_HI_DIR = 16'hFFD4;
  localparam logic [15:0] TPOU_IDX_HI_DATA = 16'hFFD6;

  // Reset values
  localparam logic [7:0] TPOU_RST_OUT_MODE = 8'hF0;
  localparam logic [7:0] TPOU_RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] TPOU_RST_ZERO = 8'h00;

  // Nibble masks of the next-pattern addresses
  localparam logic [7:0] TPOU_MASK_ALL = 8'hFF;
  localparam logic [7:0] TPOU_MASK_NONE = 8'h00;
  localparam logic [7:0] TPOU_MASK_UPPER = 8'hF0;
  localparam logic [7:0] TPOU_MASK_LOWER = 8'h0F;

  // Geometry and trigger select field
  localparam int TPOU_GROUPS = 4;
  localparam int TPOU_GROUP_BITS = 4;
  localparam int TPOU_OUTPUTS = 16;
  localparam int TPOU_SEL_W = 2;
  localparam int TPOU_CHANNELS = 4;

  // Pattern pins: level and drive enable per output
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] drive;
  } tpou_pins_s;

endpackage : tpou_pkg

/* File: hw/tpou_top.sv */
// Timing pattern output unit: sixteen outputs in four groups, reloaded from
// next-pattern registers on a selected timer compare-match pulse.
// Assumes one-cycle compare-match pulses on clk_sys and a classic Wishbone
// master that holds each request until ack.
`timescale 1ns/1ps

module tpou_top #(
  parameter int ADR_W = 18
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hwStandby,
  input wire logic [3:0] compareMatch,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [ADR_W-1:0] wbAdr,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  output tpou_pkg::tpou_pins_s pins
);
  import tpou_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Compare-match pulse chosen by one group's select field
  function automatic logic groupFire(input logic [7:0] sel, input logic [3:0] cm, input int grp);
    logic [1:0] code;
    code = sel[grp*TPOU_SEL_W +: TPOU_SEL_W];
    groupFire = cm[code];
  endfunction : groupFire

  // Bits of a next-pattern address that reach the register
  function automatic logic [7:0] nextMask(input logic shared, input logic primary);
    logic [7:0] m;
    m = TPOU_MASK_NONE;
    if (shared) begin
      m = primary ? TPOU_MASK_ALL : TPOU_MASK_NONE;
    end else begin
      m = primary ? TPOU_MASK_UPPER : TPOU_MASK_LOWER;
    end
    nextMask = m;
  endfunction : nextMask

  // Read view: unmapped bits of the address read as one
  function automatic logic [7:0] nextView(input logic [7:0] value, input logic [7:0] mask);
    nextView = (value & mask) | ~mask;
  endfunction : nextView

  // Two groups of one half share a trigger when their fields match
  function automatic logic pairShared(input logic [7:0] sel, input int pair);
    logic [1:0] lowCode;
    logic [1:0] highCode;
    lowCode = sel[2*pair*TPOU_SEL_W +: TPOU_SEL_W];
    highCode = sel[(2*pair+1)*TPOU_SEL_W +: TPOU_SEL_W];
    pairShared = lowCode == highCode;
  endfunction : pairShared

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] outModeReg;
  logic [7:0] trigSelReg;
  logic [7:0] hiEnReg;
  logic [7:0] loEnReg;
  logic [7:0] hiNextReg;
  logic [7:0] loNextReg;
  logic [7:0] loDirReg;
  logic [7:0] hiDirReg;
  logic [7:0] loDataReg;
  logic [7:0] loDataNext;
  logic [7:0] hiDataReg;
  logic [7:0] hiDataNext;
  logic ackReg;
  logic [31:0] rdDataReg;
  logic [7:0] rdByte;

  // Hardware standby initialises the registers like reset; bus ack and read data reset on rst only
  logic init;
  assign init = rst | hwStandby;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [15:0] adrIdx;
  logic busReq;
  logic wrCommit;
  logic [7:0] wrByte;

  assign adrIdx = wbAdr[17:2];
  assign busReq = wbCyc & wbStb;
  // Write lands on the edge at which the master sees ack
  assign wrCommit = busReq & wbWe & ackReg & wbSel[0];
  // Only byte lane 0 carries a register; upper lanes read zero
  assign wrByte = wbDatW[7:0];

  function automatic logic wrHit(input logic [15:0] idx, input logic [15:0] target, input logic go);
    wrHit = go & (idx == target);
  endfunction : wrHit

  // Decoded once here, so each register block tests one strobe, a next-pattern block two
  logic wrOutMode;
  logic wrTrigSel;
  logic wrHiEn;
  logic wrLoEn;
  logic wrHiNext;
  logic wrLoNext;
  logic wrHiNextAlt;
  logic wrLoNextAlt;
  logic wrLoDir;
  logic wrHiDir;
  logic wrLoData;
  logic wrHiData;

  assign wrOutMode = wrHit(adrIdx, TPOU_IDX_OUT_MODE, wrCommit);
  assign wrTrigSel = wrHit(adrIdx, TPOU_IDX_TRIG_SEL, wrCommit);
  assign wrHiEn = wrHit(adrIdx, TPOU_IDX_HI_EN, wrCommit);
  assign wrLoEn = wrHit(adrIdx, TPOU_IDX_LO_EN, wrCommit);
  assign wrHiNext = wrHit(adrIdx, TPOU_IDX_HI_NEXT, wrCommit);
  assign wrLoNext = wrHit(adrIdx, TPOU_IDX_LO_NEXT, wrCommit);
  assign wrHiNextAlt = wrHit(adrIdx, TPOU_IDX_HI_NEXT_ALT, wrCommit);
  assign wrLoNextAlt = wrHit(adrIdx, TPOU_IDX_LO_NEXT_ALT, wrCommit);
  assign wrLoDir = wrHit(adrIdx, TPOU_IDX_LO_DIR, wrCommit);
  assign wrHiDir = wrHit(adrIdx, TPOU_IDX_HI_DIR, wrCommit);
  assign wrLoData = wrHit(adrIdx, TPOU_IDX_LO_DATA, wrCommit);
  assign wrHiData = wrHit(adrIdx, TPOU_IDX_HI_DATA, wrCommit);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger grouping

  logic loShared;
  logic hiShared;
  logic [7:0] loPrimMask;
  logic [7:0] loAltMask;
  logic [7:0] hiPrimMask;
  logic [7:0] hiAltMask;

  // Sharing is judged on the current select fields, so rewriting them
  // moves the nibbles between addresses at once
  assign loShared = pairShared(trigSelReg, 0);
  assign hiShared = pairShared(trigSelReg, 1);
  assign loPrimMask = nextMask(loShared, 1'b1);
  assign loAltMask = nextMask(loShared, 1'b0);
  assign hiPrimMask = nextMask(hiShared, 1'b1);
  assign hiAltMask = nextMask(hiShared, 1'b0);

  // Per-group fire and transfer masks over all sixteen outputs
  logic [TPOU_GROUPS-1:0] fire;
  logic [TPOU_OUTPUTS-1:0] fireBits;
  logic [TPOU_OUTPUTS-1:0] xferMask;

  genvar g;
  generate
    for (g = 0; g < TPOU_GROUPS; g++) begin : gGroup
      assign fire[g] = groupFire(trigSelReg, compareMatch, g);
      assign fireBits[g*TPOU_GROUP_BITS +: TPOU_GROUP_BITS] = {TPOU_GROUP_BITS{fire[g]}};
    end
  endgenerate

  assign xferMask = fireBits & {hiEnReg, loEnReg};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Output mode is stored only; no non-overlap timing is generated
  always_ff @(posedge clk_sys) begin
    if (init) begin
      outModeReg <= TPOU_RST_OUT_MODE;
    end else if (wrOutMode) begin
      outModeReg <= wrByte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      trigSelReg <= TPOU_RST_TRIG_SEL;
    end else if (wrTrigSel) begin
      trigSelReg <= wrByte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      hiEnReg <= TPOU_RST_ZERO;
    end else if (wrHiEn) begin
      hiEnReg <= wrByte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      loEnReg <= TPOU_RST_ZERO;
    end else if (wrLoEn) begin
      loEnReg <= wrByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-pattern registers

  // A write in the cycle of a trigger lands after the old value went out
  always_ff @(posedge clk_sys) begin
    if (init) begin
      loNextReg <= TPOU_RST_ZERO;
    end else if (wrLoNext) begin
      loNextReg <= (loNextReg & ~loPrimMask) | (wrByte & loPrimMask);
    end else if (wrLoNextAlt) begin
      loNextReg <= (loNextReg & ~loAltMask) | (wrByte & loAltMask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      hiNextReg <= TPOU_RST_ZERO;
    end else if (wrHiNext) begin
      hiNextReg <= (hiNextReg & ~hiPrimMask) | (wrByte & hiPrimMask);
    end else if (wrHiNextAlt) begin
      hiNextReg <= (hiNextReg & ~hiAltMask) | (wrByte & hiAltMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction registers

  // Drive enables only; sensing pins as inputs belongs to the port logic
  always_ff @(posedge clk_sys) begin
    if (init) begin
      loDirReg <= TPOU_RST_ZERO;
    end else if (wrLoDir) begin
      loDirReg <= wrByte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      hiDirReg <= TPOU_RST_ZERO;
    end else if (wrHiDir) begin
      hiDirReg <= wrByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port data registers

  // Write mask and transfer mask are disjoint, so both may act in one cycle
  always_comb begin
    loDataNext = loDataReg;
    if (wrLoData) begin
      loDataNext = (loDataReg & loEnReg) | (wrByte & ~loEnReg);
    end
    loDataNext = (loDataNext & ~xferMask[7:0]) | (loNextReg & xferMask[7:0]);
  end

  always_comb begin
    hiDataNext = hiDataReg;
    if (wrHiData) begin
      hiDataNext = (hiDataReg & hiEnReg) | (wrByte & ~hiEnReg);
    end
    hiDataNext = (hiDataNext & ~xferMask[15:8]) | (hiNextReg & xferMask[15:8]);
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      loDataReg <= TPOU_RST_ZERO;
    end else begin
      loDataReg <= loDataNext;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      hiDataReg <= TPOU_RST_ZERO;
    end else begin
      hiDataReg <= hiDataNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Direction registers are write-only and read as zero
  always_comb begin
    rdByte = TPOU_RST_ZERO;
    case (adrIdx)
      TPOU_IDX_OUT_MODE: begin
        rdByte = outModeReg;
      end
      TPOU_IDX_TRIG_SEL: begin
        rdByte = trigSelReg;
      end
      TPOU_IDX_HI_EN: begin
        rdByte = hiEnReg;
      end
      TPOU_IDX_LO_EN: begin
        rdByte = loEnReg;
      end
      TPOU_IDX_HI_NEXT: begin
        rdByte = nextView(hiNextReg, hiPrimMask);
      end
      TPOU_IDX_LO_NEXT: begin
        rdByte = nextView(loNextReg, loPrimMask);
      end
      TPOU_IDX_HI_NEXT_ALT: begin
        rdByte = nextView(hiNextReg, hiAltMask);
      end
      TPOU_IDX_LO_NEXT_ALT: begin
        rdByte = nextView(loNextReg, loAltMask);
      end
      TPOU_IDX_LO_DATA: begin
        rdByte = loDataReg;
      end
      TPOU_IDX_HI_DATA: begin
        rdByte = hiDataReg;
      end
      default: begin
        rdByte = TPOU_RST_ZERO;
      end
    endcase
  end

  // One wait cycle: ack and data appear the cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= busReq & ~ackReg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdDataReg <= 32'h0000_0000;
    end else if (busReq & ~ackReg & ~wbWe) begin
      rdDataReg <= {24'h00_0000, rdByte};
    end
  end

  assign wbAck = ackReg;
  assign wbDatR = rdDataReg;

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  // Drive follows direction bits; software must set them for pattern pins
  assign pins.level = {hiDataReg, loDataReg};
  assign pins.drive = {hiDirReg, loDirReg};

endmodule : tpou_top

/* File: bench/tpou_timer_model.sv */
// Timer model: turns bench fire requests into compare-match pulses.
// Assumes requests change just after rising edges of clk_sys.
`timescale 1ns/1ps
module tpou_timer_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] fireReq,
  output logic [3:0] compareMatch
);
  logic [3:0] fireLast_reg;
  // Edge detect: a held request still gives one pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fireLast_reg <= 4'h0;
      compareMatch <= 4'h0;
    end else begin
      fireLast_reg <= fireReq;
      compareMatch <= fireReq & ~fireLast_reg;
    end
  end
endmodule : tpou_timer_model

/* File: bench/tpou_chk.sv */
// Checker of bus answers and pin changes of the pattern unit.
// Bound to tpou_top; sees its ports only.
`timescale 1ns/1ps
module tpou_chk #(
  parameter int ADR_W = 18
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hwStandby,
  input wire logic [3:0] compareMatch,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [ADR_W-1:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  input wire tpou_pkg::tpou_pins_s pins
);
  import tpou_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic wrAck;
  logic isDir;
  logic [15:0] idx;
  assign idx = 16'(wbAdr >> 2);
  assign wrAck = wbAck && wbWe && wbSel[0];
  assign isDir = (idx == TPOU_IDX_LO_DIR) || (idx == TPOU_IDX_HI_DIR);
  ////////////////////////////////////////////////////////////////
  property p_ack_next;
    wbCyc && wbStb && !wbAck |=> wbAck;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wbAck) |-> $past(wbCyc && wbStb);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rd_hi;
    wbAck && !wbWe |-> wbDatR[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  property p_dir_rd;
    wbAck && !wbWe && isDir |-> wbDatR == 32'h00000000;
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction register readable");
  property p_level_hold;
    $changed(pins.level) |-> $past((|compareMatch) || wrAck || hwStandby || rst);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("pin level moved without cause");
  property p_drive_hold;
    $changed(pins.drive) |-> $past((wrAck && isDir) || hwStandby || rst);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("pin drive moved without write");
  property p_lo_dir;
    wrAck && idx == TPOU_IDX_LO_DIR && !hwStandby |=> pins.drive[7:0] == $past(wbDatW[7:0]);
  endproperty
  a_lo_dir: assert property (p_lo_dir) else $error("low direction write lost");
endmodule : tpou_chk
bind tpou_top tpou_chk #(.ADR_W(ADR_W)) u_chk (.clk_sys(clk_sys), .rst(rst), .hwStandby(hwStandby),
  .compareMatch(compareMatch), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr),
  .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .pins(pins));

/* File: bench/tb_timing_pattern_output_unit.sv */
// Bench of the pattern unit: bus tasks, scenarios, verdict.
// Assumes the timer model and the bound checker are compiled.
`timescale 1ns/1ps
module tb_timing_pattern_output_unit;
  import tpou_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hwStandby = 1'b0;
  logic [3:0] fireReq = 4'h0;
  logic [3:0] compareMatch;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbSel = 4'h0;
  logic [17:0] wbAdr = 18'h00000;
  logic [31:0] wbDatW = 32'h00000000;
  logic [31:0] wbDatR;
  logic wbAck;
  tpou_pins_s pins;
  logic [7:0] rd;
  int err_count = 0;
  int checks = 0;
  always #20 clk_sys = ~clk_sys;
  tpou_timer_model TMR (.clk_sys(clk_sys), .rst(rst), .fireReq(fireReq), .compareMatch(compareMatch));
  tpou_top DUT (.clk_sys(clk_sys), .rst(rst), .hwStandby(hwStandby), .compareMatch(compareMatch),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .pins(pins));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin
  // Holds the request until ack; no latency assumed
  task automatic xfer(input logic [15:0] idx, input logic we, input logic [7:0] d, input logic [3:0] sel);
    int n;
    @(posedge clk_sys);
    {wbCyc, wbStb, wbWe, wbSel} <= {1'b1, 1'b1, we, sel};
    wbAdr <= {idx, 2'b00};
    wbDatW <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatR[7:0];
    {wbCyc, wbStb} <= 2'b00;
    if (n >= 20) err_count++;
  endtask : xfer
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d, 4'hF);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00, 4'hF);
    chk_rd(rd, exp);
  endtask : rdc
  task automatic fire(input logic [3:0] m);
    @(posedge clk_sys);
    fireReq <= m;
    @(posedge clk_sys);
    fireReq <= 4'h0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : fire
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [15:0] a [10];
    logic [7:0] e [10];
    a = '{TPOU_IDX_OUT_MODE, TPOU_IDX_TRIG_SEL, TPOU_IDX_HI_EN, TPOU_IDX_LO_EN, TPOU_IDX_HI_NEXT,
      TPOU_IDX_LO_NEXT, TPOU_IDX_HI_NEXT_ALT, TPOU_IDX_LO_NEXT_ALT, TPOU_IDX_LO_DATA, TPOU_IDX_HI_DATA};
    e = '{8'hF0, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rdc(a[i], e[i]);
    end
    chk_pin(pins.drive, 16'h0000);
  endtask : t_reset
  task automatic t_same;
    wr(TPOU_IDX_LO_DIR, 8'hFF);
    wr(TPOU_IDX_HI_DIR, 8'hFF);
    wr(TPOU_IDX_LO_EN, 8'hFF);
    wr(TPOU_IDX_HI_EN, 8'hFF);
    wr(TPOU_IDX_LO_NEXT, 8'hA5);
    wr(TPOU_IDX_HI_NEXT, 8'h3C);
    wr(TPOU_IDX_LO_NEXT_ALT, 8'h12);
    rdc(TPOU_IDX_LO_NEXT_ALT, 8'hFF);
    rdc(TPOU_IDX_LO_NEXT, 8'hA5);
    chk_pin(pins.drive, 16'hFFFF);
    rdc(TPOU_IDX_LO_DIR, 8'h00);
    rdc(TPOU_IDX_HI_DIR, 8'h00);
    fire(4'h7);
    chk_pin(pins.level, 16'h0000);
    fire(4'h8);
    chk_pin(pins.level, 16'h3CA5);
    wr(TPOU_IDX_LO_DATA, 8'h00);
    wr(TPOU_IDX_HI_DATA, 8'h00);
    rdc(TPOU_IDX_LO_DATA, 8'hA5);
    rdc(TPOU_IDX_HI_DATA, 8'h3C);
  endtask : t_same
  // Each group on its own channel, so both halves split
  task automatic t_split;
    logic [15:0] ex;
    logic [15:0] nx;
    int g;
    ex = 16'h3CA5;
    wr(TPOU_IDX_TRIG_SEL, 8'h1B);
    for (int c = 0; c < 4; c++) begin
      nx[7:0] = 8'(8'h11 * (c + 1));
      nx[15:8] = ~nx[7:0];
      wr(TPOU_IDX_LO_NEXT, nx[7:0]);
      wr(TPOU_IDX_LO_NEXT_ALT, nx[7:0]);
      wr(TPOU_IDX_HI_NEXT, nx[15:8]);
      wr(TPOU_IDX_HI_NEXT_ALT, nx[15:8]);
      rdc(TPOU_IDX_LO_NEXT, {nx[7:4], 4'hF});
      rdc(TPOU_IDX_LO_NEXT_ALT, {4'hF, nx[3:0]});
      rdc(TPOU_IDX_HI_NEXT, {nx[15:12], 4'hF});
      rdc(TPOU_IDX_HI_NEXT_ALT, {4'hF, nx[11:8]});
      g = 3 - c;
      ex[4*g+:4] = nx[4*g+:4];
      fire(4'h1 << c);
      chk_pin(pins.level, ex);
    end
  endtask : t_split
  task automatic t_enable;
    wr(TPOU_IDX_TRIG_SEL, 8'hFF);
    wr(TPOU_IDX_LO_EN, 8'h0F);
    wr(TPOU_IDX_HI_EN, 8'hF0);
    wr(TPOU_IDX_LO_NEXT, 8'h00);
    wr(TPOU_IDX_HI_NEXT, 8'h00);
    fire(4'h8);
    chk_pin(pins.level, 16'h0D30);
    wr(TPOU_IDX_LO_DATA, 8'hFF);
    rdc(TPOU_IDX_LO_DATA, 8'hF0);
    wr(16'hFFB0, 8'h5A);
    rdc(16'hFFB0, 8'h00);
    wr(TPOU_IDX_LO_NEXT, 8'h5A);
    @(posedge clk_sys);
    hwStandby <= 1'b1;
    repeat (2) @(posedge clk_sys);
    hwStandby <= 1'b0;
    rdc(TPOU_IDX_LO_NEXT, 8'h00);
    rdc(TPOU_IDX_TRIG_SEL, 8'hFF);
    chk_pin(pins.level, 16'h0000);
    wr(TPOU_IDX_OUT_MODE, 8'h3C);
    xfer(TPOU_IDX_OUT_MODE, 1'b1, 8'h55, 4'hE);
    rdc(TPOU_IDX_OUT_MODE, 8'h3C);
  endtask : t_enable
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_same();
    t_split();
    t_enable();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    test_done();
  end
  initial begin
    #100000;
    err_count++;
    test_done();
  end
endmodule : tb_timing_pattern_output_unit
